// ---- pkg/interrupt_arbiter_defines.svh ----
// Constants for the interrupt priority and acceptance block
//
// Operation
// - Priority is a level from 0 (lowest) to 16 (highest).
// - The non-maskable request has fixed level 16 and is never blocked by the mask.
// - The user break request has fixed level 15 and is still compared with the mask.
// - External and peripheral requests carry programmed levels 0 to 15 only, never 16.
// - Of all requests pending in a cycle only the highest level goes to exception handling.
// - A maskable request is accepted only when its level is above the four-bit mask field.
// - Exception entry pushes the status word and then the program counter before the handler.
// - The accepted level is loaded into the mask field of the status word.
// - For the non-maskable request the mask field is loaded with all ones.
// - The handler address is read from the source's vector entry and execution branches there.
`ifndef INTERRUPT_ARBITER_DEFINES_SVH
`define INTERRUPT_ARBITER_DEFINES_SVH

// ====================================================================
// Levels
`define LVL_NMI          5'h10
`define LVL_UBRK         5'h0f
`define MASK_NMI         4'hf
`define MASK_LSB         4
`define MASK_MSB         7

// ====================================================================
// Vector numbers
`define VEC_NMI          8'h0b
`define VEC_UBRK         8'h0c
`define VEC_IRQ_BASE     8'h40
`define VEC_PERIPH_BASE  8'h50

// ====================================================================
// Stack frame
`define SP_SR_OFS        32'h00000004
`define SP_PC_OFS        32'h00000008
`define RST_WORD         32'h00000000

`endif

// ---- pkg/interrupt_arbiter_pkg.sv ----
// Types for the interrupt priority and acceptance block
package interrupt_arbiter_pkg;

    // ================================================================
    // Entry sequence states
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_PUSH_SR = 4'h2,
        ST_PUSH_PC = 4'h4,
        ST_FETCH   = 4'h8
    } entry_state_t;

    // ================================================================
    // Memory request toward the bus
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    // ================================================================
    // Arbitration result
    typedef struct packed {
        logic       valid;
        logic       nmi;
        logic [4:0] level;
        logic [7:0] vector;
    } winner_t;

endpackage

// ---- hw/interrupt_arbiter.sv ----
// Interrupt priority resolution and exception entry sequencer
`timescale 1ns/1ps
`include "interrupt_arbiter_defines.svh"

module interrupt_arbiter #(
    parameter int NUM_IRQ    = 8,
    parameter int NUM_PERIPH = 16
) (
    // Clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              rst_n,
    // Interrupt sources
    input  wire logic                              nmi_req,
    input  wire logic                              ubrk_req,
    input  wire logic [NUM_IRQ-1:0]                irq_req,
    input  wire logic [NUM_IRQ-1:0][3:0]           irq_level,
    input  wire logic [NUM_PERIPH-1:0]             periph_req,
    input  wire logic [NUM_PERIPH-1:0][3:0]        periph_level,
    // CPU state
    input  wire logic                              cpu_boundary,
    input  wire logic [31:0]                       cpu_status_word,
    input  wire logic [31:0]                       cpu_pc,
    input  wire logic [31:0]                       cpu_sp,
    input  wire logic [31:0]                       cpu_vbr,
    // Memory port
    output interrupt_arbiter_pkg::mem_req_t                     mem_out,
    input  wire logic                              mem_ack,
    input  wire logic [31:0]                       mem_rdata,
    // CPU updates
    output logic                                   entry_busy,
    output logic                                   sr_load,
    output logic [31:0]                            sr_value,
    output logic                                   sp_load,
    output logic [31:0]                            sp_value,
    output logic                                   pc_load,
    output logic [31:0]                            pc_value,
    output logic                                   int_ack,
    output logic [7:0]                             int_ack_vector
);

    // ================================================================
    // Registers
    interrupt_arbiter_pkg::entry_state_t state_reg;
    interrupt_arbiter_pkg::mem_req_t     mem_reg;
    interrupt_arbiter_pkg::winner_t      win;
    interrupt_arbiter_pkg::winner_t      taken_reg;
    logic [31:0]            saved_sr_reg;
    logic [31:0]            saved_pc_reg;
    logic [31:0]            saved_sp_reg;
    logic                   busy_reg;
    logic                   sr_load_reg;
    logic [31:0]            sr_value_reg;
    logic                   sp_load_reg;
    logic [31:0]            sp_value_reg;
    logic                   pc_load_reg;
    logic [31:0]            pc_value_reg;
    logic                   ack_reg;
    logic [7:0]             ack_vec_reg;
    logic [3:0]             mask;
    logic                   accept;
    logic                   beaten;

    assign mask = cpu_status_word[`MASK_MSB:`MASK_LSB];

    // ================================================================
    // Priority resolution
    always_comb begin
        win = '0;
        if (nmi_req) begin
            win = {1'b1, 1'b1, `LVL_NMI, `VEC_NMI};
        end
        if (ubrk_req && (!win.valid || `LVL_UBRK > win.level)) begin
            win = {1'b1, 1'b0, `LVL_UBRK, `VEC_UBRK};
        end
        // Strict compare keeps the earlier source on a tie
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (irq_req[i] && (!win.valid || {1'b0, irq_level[i]} > win.level)) begin
                win.valid  = 1'b1;
                win.nmi    = 1'b0;
                win.level  = {1'b0, irq_level[i]};
                win.vector = `VEC_IRQ_BASE + 8'(i);
            end
        end
        for (int j = 0; j < NUM_PERIPH; j++) begin
            if (periph_req[j] && (!win.valid || {1'b0, periph_level[j]} > win.level)) begin
                win.valid  = 1'b1;
                win.nmi    = 1'b0;
                win.level  = {1'b0, periph_level[j]};
                win.vector = `VEC_PERIPH_BASE + 8'(j);
            end
        end
    end

    // Mask comparison; the non-maskable source bypasses it
    assign accept = win.valid && (win.nmi || win.level > {1'b0, mask});

    // Check that no pending external or peripheral request outranks the winner
    always_comb begin
        beaten = 1'b0;
        for (int k = 0; k < NUM_IRQ; k++) begin
            if (irq_req[k] && {1'b0, irq_level[k]} > win.level) begin
                beaten = 1'b1;
            end
        end
        for (int m = 0; m < NUM_PERIPH; m++) begin
            if (periph_req[m] && {1'b0, periph_level[m]} > win.level) begin
                beaten = 1'b1;
            end
        end
    end

    // ================================================================
    // Entry sequence state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= interrupt_arbiter_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                interrupt_arbiter_pkg::ST_IDLE: begin
                    if (cpu_boundary && accept) begin
                        state_reg <= interrupt_arbiter_pkg::ST_PUSH_SR;
                    end
                end
                interrupt_arbiter_pkg::ST_PUSH_SR: begin
                    if (mem_ack) begin
                        state_reg <= interrupt_arbiter_pkg::ST_PUSH_PC;
                    end
                end
                interrupt_arbiter_pkg::ST_PUSH_PC: begin
                    if (mem_ack) begin
                        state_reg <= interrupt_arbiter_pkg::ST_FETCH;
                    end
                end
                interrupt_arbiter_pkg::ST_FETCH: begin
                    if (mem_ack) begin
                        state_reg <= interrupt_arbiter_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= interrupt_arbiter_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ================================================================
    // Capture of the accepted request and CPU context
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            taken_reg    <= '0;
            saved_sr_reg <= `RST_WORD;
            saved_pc_reg <= `RST_WORD;
            saved_sp_reg <= `RST_WORD;
        end else if (state_reg == interrupt_arbiter_pkg::ST_IDLE && cpu_boundary && accept) begin
            taken_reg    <= win;
            saved_sr_reg <= cpu_status_word;
            saved_pc_reg <= cpu_pc;
            saved_sp_reg <= cpu_sp;
        end
    end

    // ================================================================
    // Memory requests: push SR, push PC, read vector
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_reg <= '0;
        end else begin
            case (state_reg)
                interrupt_arbiter_pkg::ST_IDLE: begin
                    if (cpu_boundary && accept) begin
                        mem_reg <= {1'b1, 1'b1, cpu_sp - `SP_SR_OFS, cpu_status_word};
                    end
                end
                interrupt_arbiter_pkg::ST_PUSH_SR: begin
                    if (mem_ack) begin
                        mem_reg <= {1'b1, 1'b1, saved_sp_reg - `SP_PC_OFS, saved_pc_reg};
                    end
                end
                interrupt_arbiter_pkg::ST_PUSH_PC: begin
                    if (mem_ack) begin
                        mem_reg <= {1'b1, 1'b0,
                                    cpu_vbr + {22'h0, taken_reg.vector, 2'h0},
                                    `RST_WORD};
                    end
                end
                interrupt_arbiter_pkg::ST_FETCH: begin
                    if (mem_ack) begin
                        mem_reg <= '0;
                    end
                end
                default: begin
                    mem_reg <= '0;
                end
            endcase
        end
    end

    // ================================================================
    // Busy flag toward the CPU
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
        end else if (state_reg == interrupt_arbiter_pkg::ST_IDLE) begin
            busy_reg <= cpu_boundary && accept;
        end else if (state_reg == interrupt_arbiter_pkg::ST_FETCH && mem_ack) begin
            busy_reg <= 1'b0;
        end
    end

    // ================================================================
    // Status word and stack pointer update after both pushes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_load_reg  <= 1'b0;
            sr_value_reg <= `RST_WORD;
            sp_load_reg  <= 1'b0;
            sp_value_reg <= `RST_WORD;
        end else begin
            sr_load_reg <= 1'b0;
            sp_load_reg <= 1'b0;
            if (state_reg == interrupt_arbiter_pkg::ST_PUSH_PC && mem_ack) begin
                sr_load_reg  <= 1'b1;
                sr_value_reg <= saved_sr_reg;
                if (taken_reg.nmi) begin
                    sr_value_reg[`MASK_MSB:`MASK_LSB] <= `MASK_NMI;
                end else begin
                    sr_value_reg[`MASK_MSB:`MASK_LSB] <= taken_reg.level[3:0];
                end
                sp_load_reg  <= 1'b1;
                sp_value_reg <= saved_sp_reg - `SP_PC_OFS;
            end
        end
    end

    // ================================================================
    // Branch to handler and acknowledge the source
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_load_reg  <= 1'b0;
            pc_value_reg <= `RST_WORD;
            ack_reg      <= 1'b0;
            ack_vec_reg  <= 8'h00;
        end else begin
            pc_load_reg <= 1'b0;
            ack_reg     <= 1'b0;
            if (state_reg == interrupt_arbiter_pkg::ST_FETCH && mem_ack) begin
                pc_load_reg  <= 1'b1;
                pc_value_reg <= mem_rdata;
                ack_reg      <= 1'b1;
                ack_vec_reg  <= taken_reg.vector;
            end
        end
    end

    assign mem_out        = mem_reg;
    assign entry_busy     = busy_reg;
    assign sr_load        = sr_load_reg;
    assign sr_value       = sr_value_reg;
    assign sp_load        = sp_load_reg;
    assign sp_value       = sp_value_reg;
    assign pc_load        = pc_load_reg;
    assign pc_value       = pc_value_reg;
    assign int_ack        = ack_reg;
    assign int_ack_vector = ack_vec_reg;

    // ================================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_level_range: assert property (win.level <= `LVL_NMI)
        else $error("winning level above 16");

    a_nmi_always_taken: assert property (
        state_reg == interrupt_arbiter_pkg::ST_IDLE && cpu_boundary && nmi_req
        |=> state_reg == interrupt_arbiter_pkg::ST_PUSH_SR && taken_reg.nmi)
        else $error("non-maskable request not accepted");

    a_ubrk_level_fixed: assert property (
        win.valid && win.vector == `VEC_UBRK |-> win.level == `LVL_UBRK
        && (accept == (`LVL_UBRK > {1'b0, mask})))
        else $error("user break level or masking wrong");

    a_no_higher_pending: assert property (!beaten)
        else $error("a higher pending request was passed over");

    a_mask_blocks: assert property (
        state_reg == interrupt_arbiter_pkg::ST_IDLE && !nmi_req && win.level <= {1'b0, mask}
        |=> state_reg == interrupt_arbiter_pkg::ST_IDLE && !busy_reg)
        else $error("masked request was accepted");

    a_push_order: assert property (
        state_reg == interrupt_arbiter_pkg::ST_PUSH_SR && mem_ack
        |=> mem_out.req && mem_out.we && mem_out.addr == saved_sp_reg - `SP_PC_OFS
        && mem_out.wdata == saved_pc_reg)
        else $error("program counter push not after status push");

    a_mask_loaded: assert property (
        sr_load && !taken_reg.nmi
        |-> sr_value[`MASK_MSB:`MASK_LSB] == taken_reg.level[3:0])
        else $error("mask field not loaded with accepted level");

    a_nmi_mask_ones: assert property (
        sr_load && taken_reg.nmi |-> sr_value[`MASK_MSB:`MASK_LSB] == `MASK_NMI)
        else $error("mask field not all ones after non-maskable entry");

    a_branch_vector: assert property (
        state_reg == interrupt_arbiter_pkg::ST_FETCH && mem_ack
        |=> pc_load && pc_value == $past(mem_rdata) && !mem_out.req)
        else $error("branch target not taken from vector read");

    a_tie_first_wins: assert property (
        !nmi_req && !ubrk_req && irq_req[0] && win.valid
        && win.level == {1'b0, irq_level[0]} |-> win.vector == `VEC_IRQ_BASE)
        else $error("tie not resolved by fixed order");

endmodule // interrupt_arbiter

// ---- test/mem_partner.sv ----
// Memory side model answering the exception entry bus cycles
`timescale 1ns/1ps

module mem_partner (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Memory port
    input  interrupt_arbiter_pkg::mem_req_t mem_out,
    output logic               mem_ack,
    output logic [31:0]        mem_rdata,
    // Pacing and log
    input  wire logic [3:0]    ack_delay,
    input  wire logic          log_clr,
    output logic [31:0]        log_addr [3],
    output logic [31:0]        log_data [3],
    output logic               log_we [3]
);
    logic [3:0] wait_reg;
    logic [1:0] idx_reg;

    // ================================================================
    // Answer after a chosen stall; data churns outside an answer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack   <= 1'b0;
            wait_reg  <= 4'h0;
            idx_reg   <= 2'h0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= mem_rdata + 32'h13579bdf;
            if (log_clr)
                idx_reg <= 2'h0;
            if (mem_out.req && !mem_ack) begin
                if (wait_reg == ack_delay) begin
                    mem_ack   <= 1'b1;
                    wait_reg  <= 4'h0;
                    mem_rdata <= ~mem_out.addr;
                    if (idx_reg < 2'h3) begin
                        log_addr[idx_reg] <= mem_out.addr;
                        log_data[idx_reg] <= mem_out.wdata;
                        log_we[idx_reg]   <= mem_out.we;
                        idx_reg           <= idx_reg + 2'h1;
                    end
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end
        end
    end
endmodule // mem_partner

// ---- test/tb_interrupt_priority_acceptance.sv ----
// Self-checking bench for the interrupt priority and acceptance block
`timescale 1ns/1ps
`include "interrupt_arbiter_defines.svh"

module tb_interrupt_priority_acceptance;
    // ================================================================
    // Signals
    logic               sys_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               nmi_req = 1'b0;
    logic               ubrk_req = 1'b0;
    logic               cpu_boundary = 1'b0;
    logic [7:0]         irq_req = '0;
    logic [7:0][3:0]    irq_level = '0;
    logic [15:0]        periph_req = '0;
    logic [15:0][3:0]   periph_level = '0;
    logic [31:0]        cpu_status_word = '0;
    logic [31:0]        cpu_pc = '0;
    logic [31:0]        cpu_sp = '0;
    logic [31:0]        cpu_vbr = '0;
    interrupt_arbiter_pkg::mem_req_t mem_out;
    logic               mem_ack;
    logic [31:0]        mem_rdata;
    logic               entry_busy, sr_load, sp_load, pc_load, int_ack;
    logic [31:0]        sr_value, sp_value, pc_value;
    logic [7:0]         int_ack_vector;
    logic [3:0]         ack_delay = 4'h0;
    logic               log_clr = 1'b1;
    logic [31:0]        log_addr [3];
    logic [31:0]        log_data [3];
    logic               log_we [3];
    int                 error_cnt = 0;
    int                 num_checks = 0;
    int                 cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    interrupt_arbiter DUT (.sys_clk(sys_clk), .rst_n(rst_n), .nmi_req(nmi_req),
        .ubrk_req(ubrk_req), .irq_req(irq_req), .irq_level(irq_level),
        .periph_req(periph_req), .periph_level(periph_level), .cpu_boundary(cpu_boundary),
        .cpu_status_word(cpu_status_word), .cpu_pc(cpu_pc), .cpu_sp(cpu_sp),
        .cpu_vbr(cpu_vbr), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .entry_busy(entry_busy), .sr_load(sr_load), .sr_value(sr_value), .sp_load(sp_load),
        .sp_value(sp_value), .pc_load(pc_load), .pc_value(pc_value), .int_ack(int_ack),
        .int_ack_vector(int_ack_vector));

    mem_partner partner (.sys_clk(sys_clk), .rst_n(rst_n), .mem_out(mem_out),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ack_delay(ack_delay),
        .log_clr(log_clr), .log_addr(log_addr), .log_data(log_data), .log_we(log_we));

    // ================================================================
    // Checking and verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // Winner by level, lower source index on ties
    function automatic interrupt_arbiter_pkg::winner_t pick();
        interrupt_arbiter_pkg::winner_t w;
        w = '0;
        if (ubrk_req)
            w = '{1'b1, 1'b0, `LVL_UBRK, `VEC_UBRK};
        for (int i = 0; i < 8; i++)
            if (irq_req[i] && (!w.valid || {1'b0, irq_level[i]} > w.level))
                w = '{1'b1, 1'b0, {1'b0, irq_level[i]}, `VEC_IRQ_BASE + 8'(i)};
        for (int j = 0; j < 16; j++)
            if (periph_req[j] && (!w.valid || {1'b0, periph_level[j]} > w.level))
                w = '{1'b1, 1'b0, {1'b0, periph_level[j]}, `VEC_PERIPH_BASE + 8'(j)};
        if (nmi_req)
            w = '{1'b1, 1'b1, `LVL_NMI, `VEC_NMI};
        return w;
    endfunction

    // ================================================================
    // One request set presented at an instruction boundary
    task automatic run(input string name);
        interrupt_arbiter_pkg::winner_t w;
        logic              acc, busy_seen, sr_seen;
        logic [31:0]       sw, va;
        int                n;
        w = pick();
        acc = w.valid && (w.nmi || w.level > {1'b0, cpu_status_word[7:4]});
        sw = cpu_status_word;
        sw[7:4] = w.nmi ? `MASK_NMI : w.level[3:0];
        va = cpu_vbr + {22'h0, w.vector, 2'b00};
        busy_seen = 1'b0;
        sr_seen = 1'b0;
        log_clr = 1'b0;
        cpu_boundary = 1'b1;
        n = 0;
        while (n < (acc ? 60 : 8) && int_ack !== 1'b1) begin
            @(posedge sys_clk);
            #2;
            n++;
            busy_seen = busy_seen | (entry_busy === 1'b1);
            if (sr_load === 1'b1) begin
                sr_seen = 1'b1;
                check(sr_value, sw, "status word");
                check(32'(sp_load), 32'h1, "sp load");
                check(sp_value, cpu_sp - 32'h8, "stack pointer");
            end
        end
        check(32'(busy_seen), 32'(acc), "entry started");
        check(32'(int_ack), 32'(acc), "acknowledge");
        if (acc) begin
            check(32'(int_ack_vector), 32'(w.vector), "vector");
            check(32'(pc_load), 32'h1, "pc load");
            check(pc_value, ~va, "handler address");
            check(32'(sr_seen), 32'h1, "status loaded");
            check(log_addr[0], cpu_sp - 32'h4, "status push address");
            check(log_data[0], cpu_status_word, "status push data");
            check(32'(log_we[0] & log_we[1]), 32'h1, "push writes");
            check(log_addr[1], cpu_sp - 32'h8, "pc push address");
            check(log_data[1], cpu_pc, "pc push data");
            check(log_addr[2], va, "vector read address");
            check(32'(log_we[2]), 32'h0, "vector read");
        end
        cpu_boundary = 1'b0;
        nmi_req = 1'b0;
        ubrk_req = 1'b0;
        irq_req = '0;
        periph_req = '0;
        log_clr = 1'b1;
        @(posedge sys_clk);
        #2;
        check(32'(entry_busy), 32'h0, "idle after entry");
        $display("test %s done", name);
    endtask

    // ================================================================
    // Main sequence
    initial begin
        void'($urandom(20));
        repeat (10) @(posedge sys_clk);
        #2;
        rst_n = 1'b1;
        @(posedge sys_clk);
        #2;
        check(32'({entry_busy, sr_load, pc_load, int_ack, mem_out.req}), 32'h0, "reset state");
        cpu_sp = 32'h00001000;
        cpu_vbr = 32'h00002000;
        cpu_pc = 32'h00000300;
        cpu_status_word = 32'h000000f0;
        nmi_req = 1'b1;
        ubrk_req = 1'b1;
        run("nmi over full mask");
        ubrk_req = 1'b1;
        run("break under full mask");
        cpu_status_word = 32'h000000e0;
        ubrk_req = 1'b1;
        irq_req = 8'h01;
        irq_level[0] = 4'hf;
        run("break ties irq");
        cpu_status_word = 32'h00000060;
        irq_req = 8'h0c;
        irq_level[2] = 4'h7;
        irq_level[3] = 4'h7;
        run("irq tie");
        irq_req = 8'h20;
        irq_level[5] = 4'h6;
        run("level equal to mask");
        cpu_status_word = 32'h00000000;
        irq_req = 8'h02;
        irq_level[1] = 4'h0;
        run("level zero");
        irq_req = 8'h10;
        irq_level[4] = 4'h8;
        periph_req = 16'h0008;
        periph_level[3] = 4'h9;
        run("periph over irq");
        // Reset in the middle of an entry
        nmi_req = 1'b1;
        cpu_boundary = 1'b1;
        repeat (3) @(posedge sys_clk);
        #2;
        check(32'(entry_busy), 32'h1, "entry under way");
        rst_n = 1'b0;
        nmi_req = 1'b0;
        cpu_boundary = 1'b0;
        @(posedge sys_clk);
        #2;
        rst_n = 1'b1;
        @(posedge sys_clk);
        #2;
        check(32'({entry_busy, sr_load, pc_load, int_ack, mem_out.req}), 32'h0, "mid reset");
        $display("test mid reset done");
        for (int t = 0; t < 60; t++) begin
            nmi_req = ($urandom % 16) == 0;
            ubrk_req = ($urandom % 8) == 0;
            irq_req = 8'($urandom) & 8'($urandom);
            irq_level = 32'($urandom);
            periph_req = 16'($urandom) & 16'($urandom) & 16'($urandom);
            periph_level = {$urandom, $urandom};
            cpu_status_word = $urandom;
            cpu_pc = $urandom;
            cpu_sp = $urandom & 32'hfffffffc;
            cpu_vbr = $urandom & 32'hfffffc00;
            ack_delay = 4'($urandom % 4);
            run("random");
        end
        print_verdict();
    end
endmodule // tb_interrupt_priority_acceptance
